// File: pkg/wdtr_pkg.sv
// Constants, register map and carrier types of the watchdog refresh block.
// Assumes a single 125 MHz clock that stands for the oscillator clock.
package wdtr_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 8000;
   localparam int OSC_PER_CYCLE = 12;
   localparam int CYCLE_TIME_PS = OSC_PER_CYCLE * CLK_PERIOD_PS;
   localparam int CLK_PER_CYCLE = (CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PRESCALE_SLOW = 128;
   localparam int PRESCALE_FAST = 2;
   localparam int ARM_LIFE_CYCLES = 3;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_RELOAD = 8'h86;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hA8;
   localparam logic [7:0] ADDR_IRQ_PRIORITY = 8'hA9;
   localparam logic [7:0] ADDR_START = 8'hB8;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'hC0;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'hC1;
   localparam logic [7:0] ADDR_EVT_STATUS = 8'hC2;
   localparam logic [7:0] ADDR_EVT_MASK = 8'hC3;

   // ------------------------------------------------------------------
   // Field positions and values
   // ------------------------------------------------------------------
   localparam int RELOAD_PRESCALE_BIT = 7;
   localparam int ARM_BIT = 6;
   localparam int START_BIT = 6;
   localparam int SOURCE_FLAG_BIT = 6;
   localparam logic [7:0] RELOAD_RESET = 8'h00;
   localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
   localparam logic [7:0] IRQ_PRIORITY_RESET = 8'h00;
   localparam logic [14:0] COUNT_RESET = 15'h0000;
   localparam logic [14:0] COUNT_TIMEOUT = 15'h7FFC;
   localparam logic [14:0] COUNT_LAST = 15'h7FFF;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Event bits of the status and mask registers
   localparam int EVT_TIMEOUT = 0;
   localparam int EVT_REFRESH = 1;
   localparam int EVT_START = 2;
   localparam int EVT_COUNT = 3;
   localparam logic [EVT_COUNT-1:0] EVT_RESET = 3'h0;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wdtr_bus_req_t;

   typedef enum logic [1:0] {
      WDTR_STOPPED,
      WDTR_RUNNING,
      WDTR_IN_RESET
   } wdtr_state_t;

endpackage

// File: hw/wdtr_tick.sv
// Machine-cycle enable and watchdog count-rate prescaler.
// Assumes clk is the oscillator clock; all outputs are one-cycle enables.
`timescale 1ns/1ps
module wdtr_tick (
   input wire logic clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic slow_sel,
   input wire logic restart,
   output logic cycle_en,
   output logic count_en
);
   import wdtr_pkg::*;

   logic [3:0] osc_cnt_reg;
   logic [6:0] pre_cnt_reg;
   logic [6:0] pre_last;

   // ------------------------------------------------------------------
   // Machine cycle of twelve oscillator periods
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         osc_cnt_reg <= 4'h0;
         cycle_en <= 1'b0;
      end else if (osc_cnt_reg == 4'(CLK_PER_CYCLE - 1)) begin
         osc_cnt_reg <= 4'h0;
         cycle_en <= 1'b1; // [RQ17]
      end else begin
         osc_cnt_reg <= osc_cnt_reg + 4'h1;
         cycle_en <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Prescaler, restarted on start and refresh so a period is whole
   // ------------------------------------------------------------------
   assign pre_last = slow_sel ? 7'(PRESCALE_SLOW - 1) : 7'(PRESCALE_FAST - 1); // [RQ1]

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pre_cnt_reg <= 7'h00;
         count_en <= 1'b0;
      end else if (!run || restart) begin
         pre_cnt_reg <= 7'h00;
         count_en <= 1'b0;
      end else if (cycle_en) begin
         count_en <= (pre_cnt_reg >= pre_last);
         pre_cnt_reg <= (pre_cnt_reg >= pre_last) ? 7'h00 : pre_cnt_reg + 7'h01;
      end else begin
         count_en <= 1'b0;
      end
   end

endmodule

// File: hw/wdtr_irq.sv
// Sticky event status, mask and level interrupt output.
// Assumes events are one-cycle pulses on the same clock as the bus.
`timescale 1ns/1ps
module wdtr_irq (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [wdtr_pkg::EVT_COUNT-1:0] evt,
   input wire logic status_w1c,
   input wire logic mask_wr,
   input wire logic [wdtr_pkg::EVT_COUNT-1:0] wdata,
   output logic [wdtr_pkg::EVT_COUNT-1:0] status_reg,
   output logic [wdtr_pkg::EVT_COUNT-1:0] mask_reg,
   output logic irq
);
   import wdtr_pkg::*;

   // ------------------------------------------------------------------
   // Status, set wins over a clear in the same cycle
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_reg <= EVT_RESET;
      end else begin
         status_reg <= (status_reg & ~(status_w1c ? wdata : EVT_RESET)) | evt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mask_reg <= EVT_RESET;
      end else if (mask_wr) begin
         mask_reg <= wdata;
      end
   end

   // Registered, so the line lags the status by one cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_reg & mask_reg);
      end
   end

endmodule

// File: hw/wdtr_top.sv
// Watchdog timer with two-step refresh, reached over a plain register port.
// Assumes the core issues one-cycle strobes and reads data one cycle later.
//
// Behaviour
// [RQ1] Fifteen-bit up-counter, rate machine cycle over 2, or over 128 with reload bit 7.
// [RQ2] On start the high byte takes the seven reload bits, low byte zero.
// [RQ3] External reset clears the whole reload register.
// [RQ4] Seven low reload bits are writable whether running or stopped.
// [RQ5] Setting bit 6 of the start register starts the watchdog.
// [RQ6] While stopped, a reload write updates the counter high byte at once.
// [RQ7] Counter low byte reads zero while stopped.
// [RQ8] Software cannot stop a started watchdog; only external reset does.
// [RQ9] Arm bit then start bit in the next instruction reloads the counter.
// [RQ10] Arm bit clears itself in the third machine cycle after being set.
// [RQ11] Internal reset raised when the running counter reaches 7FFC.
// [RQ12] Internal reset length follows the selected prescaler.
// [RQ13] Watchdog reset acts as external reset but keeps running and sets flag.
// [RQ14] Software may clear the reset-source flag by writing it.
// [RQ15] External reset clears the reset-source flag.
// [RQ16] Software must refresh within the time-out or the device resets.
// [RQ17] A machine cycle spans twelve oscillator periods.
// [RQ18] After a watchdog reset the counter reloads and runs on unprompted.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module wdtr_top (
   input wire logic clk,
   input wire logic resetn,
   input wire wdtr_pkg::wdtr_bus_req_t bus_req,
   output logic [7:0] rdata,
   output logic wd_reset_out,
   output logic irq
);
   import wdtr_pkg::*;

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   wdtr_state_t state_reg;
   logic [7:0] wd_reload_reg;
   logic [7:0] irq_enable_reg;
   logic [7:0] irq_priority_reg;
   logic [14:0] count_reg;
   logic [1:0] arm_age_reg;
   logic wd_reset_reg;
   logic wd_reset_source_flag;
   logic cycle_en;
   logic count_en;
   logic wr_reload;
   logic wr_enable;
   logic wr_priority;
   logic wr_start;
   logic wr_status;
   logic wr_mask;
   logic wd_refresh_arm;
   logic wd_start_bit;
   logic do_start;
   logic do_refresh;
   logic running;
   logic at_timeout;
   logic at_last;
   logic timeout_evt;
   logic [EVT_COUNT-1:0] evt;
   logic [EVT_COUNT-1:0] evt_status;
   logic [EVT_COUNT-1:0] evt_mask;
   logic [7:0] wd_count_low;
   logic [7:0] wd_count_high;

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   assign wr_reload = bus_req.wr && (bus_req.addr == ADDR_RELOAD);
   assign wr_enable = bus_req.wr && (bus_req.addr == ADDR_IRQ_ENABLE);
   assign wr_priority = bus_req.wr && (bus_req.addr == ADDR_IRQ_PRIORITY);
   assign wr_start = bus_req.wr && (bus_req.addr == ADDR_START);
   assign wr_status = bus_req.wr && (bus_req.addr == ADDR_EVT_STATUS);
   assign wr_mask = bus_req.wr && (bus_req.addr == ADDR_EVT_MASK);

   assign wd_refresh_arm = irq_enable_reg[ARM_BIT];
   assign wd_start_bit = bus_req.wdata[START_BIT];
   assign running = (state_reg != WDTR_STOPPED);

   // Start from stopped; refresh only while the arm bit still stands
   assign do_start = wr_start && wd_start_bit && (state_reg == WDTR_STOPPED); // [RQ5]
   assign do_refresh = wr_start && wd_start_bit && running && wd_refresh_arm; // [RQ9]

   // Fires on the tick that lands on 7FFC, so the reset covers 7FFC to 7FFF
   assign at_timeout = ((count_reg + 15'h0001) == COUNT_TIMEOUT);
   assign at_last = (count_reg == COUNT_LAST);
   assign timeout_evt = count_en && (state_reg == WDTR_RUNNING) && at_timeout && !do_refresh;

   // ------------------------------------------------------------------
   // Machine cycle and prescaler
   // ------------------------------------------------------------------
   wdtr_tick u_tick (
      .clk(clk),
      .resetn(resetn),
      .run(running),
      .slow_sel(wd_reload_reg[RELOAD_PRESCALE_BIT]),
      .restart(do_start || do_refresh),
      .cycle_en(cycle_en),
      .count_en(count_en)
   );

   // ------------------------------------------------------------------
   // Run state; no write path leads back to stopped
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= WDTR_STOPPED; // [RQ8]
      end else begin
         case (state_reg)
            WDTR_STOPPED: begin
               if (do_start) begin
                  state_reg <= WDTR_RUNNING;
               end
            end
            WDTR_RUNNING: begin
               if (timeout_evt) begin
                  state_reg <= WDTR_IN_RESET; // [RQ11]
               end
            end
            WDTR_IN_RESET: begin
               // Reset ends at the wrap, four prescaled ticks later
               if (count_en && at_last) begin
                  state_reg <= WDTR_RUNNING; // [RQ18]
               end
            end
            default: begin
               state_reg <= WDTR_STOPPED;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Reload and prescaler select
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wd_reload_reg <= RELOAD_RESET; // [RQ3]
      end else if (wr_reload) begin
         // Accepted in any state; bit 7 acts at once, bits 6:0 reach the counter at once while stopped, else at the next reload
         wd_reload_reg <= bus_req.wdata; // [RQ4]
      end
   end

   // ------------------------------------------------------------------
   // Watchdog counter
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_reg <= COUNT_RESET;
      end else if (state_reg == WDTR_STOPPED) begin
         if (do_start) begin
            count_reg <= {wd_reload_reg[6:0], 8'h00}; // [RQ2]
         end else if (wr_reload) begin
            count_reg <= {bus_req.wdata[6:0], 8'h00}; // [RQ6] [RQ7]
         end else begin
            count_reg <= {count_reg[14:8], 8'h00}; // [RQ7]
         end
      end else if (do_refresh) begin
         count_reg <= {wd_reload_reg[6:0], 8'h00}; // [RQ9]
      end else if (count_en) begin
         if (at_last) begin
            count_reg <= {wd_reload_reg[6:0], 8'h00}; // [RQ18]
         end else begin
            count_reg <= count_reg + 15'h0001; // [RQ1]
         end
      end
   end

   // ------------------------------------------------------------------
   // Internal reset output, from 7FFC up to the wrap
   // ------------------------------------------------------------------
   // Held for four count ticks, so it scales with the prescaler
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wd_reset_reg <= 1'b0;
      end else if (timeout_evt) begin
         wd_reset_reg <= 1'b1; // [RQ11] [RQ12]
      end else if ((state_reg == WDTR_IN_RESET) && count_en && at_last) begin
         wd_reset_reg <= 1'b0; // [RQ12]
      end
   end

   assign wd_reset_out = wd_reset_reg;

   // ------------------------------------------------------------------
   // Arm bit and its three machine-cycle life
   // ------------------------------------------------------------------
   // The core owns the other enable bits; they are plain storage here
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_enable_reg <= IRQ_ENABLE_RESET;
         arm_age_reg <= 2'h0;
      end else if (wd_reset_reg || timeout_evt) begin
         // Cleared with the rising edge of the reset, so no read sees a stale arm
         irq_enable_reg <= IRQ_ENABLE_RESET; // [RQ13]
         arm_age_reg <= 2'h0;
      end else if (wr_enable) begin
         irq_enable_reg <= bus_req.wdata;
         arm_age_reg <= 2'h0;
      end else if (do_refresh) begin
         // A used arm cannot trigger a second refresh
         irq_enable_reg[ARM_BIT] <= 1'b0;
         arm_age_reg <= 2'h0;
      end else if (wd_refresh_arm && cycle_en) begin
         if (arm_age_reg == 2'(ARM_LIFE_CYCLES - 1)) begin
            irq_enable_reg[ARM_BIT] <= 1'b0; // [RQ10]
            arm_age_reg <= 2'h0;
         end else begin
            arm_age_reg <= arm_age_reg + 2'h1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Priority register with the reset-source flag
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_priority_reg <= IRQ_PRIORITY_RESET; // [RQ15]
      end else begin
         if (wr_priority) begin
            irq_priority_reg <= bus_req.wdata; // [RQ14]
         end
         if (timeout_evt) begin
            // Set wins over a software clear in the same cycle
            irq_priority_reg[SOURCE_FLAG_BIT] <= 1'b1; // [RQ13]
         end
      end
   end

   assign wd_reset_source_flag = irq_priority_reg[SOURCE_FLAG_BIT];

   // ------------------------------------------------------------------
   // Event interrupts
   // ------------------------------------------------------------------
   always_comb begin
      evt = EVT_RESET;
      evt[EVT_TIMEOUT] = timeout_evt;
      evt[EVT_REFRESH] = do_refresh;
      evt[EVT_START] = do_start;
   end

   wdtr_irq u_irq (
      .clk(clk),
      .resetn(resetn),
      .evt(evt),
      .status_w1c(wr_status),
      .mask_wr(wr_mask),
      .wdata(bus_req.wdata[EVT_COUNT-1:0]),
      .status_reg(evt_status),
      .mask_reg(evt_mask),
      .irq(irq)
   );

   // ------------------------------------------------------------------
   // Read data, valid the cycle after the strobe only
   // ------------------------------------------------------------------
   assign wd_count_low = count_reg[7:0];
   assign wd_count_high = {1'b0, count_reg[14:8]};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= READ_UNMAPPED;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            ADDR_RELOAD: begin
               rdata <= wd_reload_reg;
            end
            ADDR_IRQ_ENABLE: begin
               rdata <= irq_enable_reg;
            end
            ADDR_IRQ_PRIORITY: begin
               rdata <= {irq_priority_reg[7], wd_reset_source_flag, irq_priority_reg[5:0]};
            end
            ADDR_START: begin
               rdata <= {1'b0, running, 6'h00};
            end
            ADDR_COUNT_LOW: begin
               rdata <= wd_count_low;
            end
            ADDR_COUNT_HIGH: begin
               rdata <= wd_count_high;
            end
            ADDR_EVT_STATUS: begin
               rdata <= {5'h00, evt_status};
            end
            ADDR_EVT_MASK: begin
               rdata <= {5'h00, evt_mask};
            end
            default: begin
               rdata <= READ_UNMAPPED;
            end
         endcase
      end else begin
         rdata <= READ_UNMAPPED;
      end
   end

endmodule

// File: testbench/wdtr_props.sv
// Port-level checks of the watchdog block.
// Assumes it is bound to wdtr_top and sees only its ports.
`timescale 1ns/1ps
module wdtr_props (
   input wire logic clk,
   input wire logic resetn,
   input wire wdtr_pkg::wdtr_bus_req_t bus_req,
   input wire logic [7:0] rdata,
   input wire logic wd_reset_out,
   input wire logic irq
);
   import wdtr_pkg::*;
   localparam int PULSE_FAST = 4 * PRESCALE_FAST * CLK_PER_CYCLE;
   localparam int PULSE_SLOW = 4 * PRESCALE_SLOW * CLK_PER_CYCLE;
   logic started_reg;
   int hi_cnt_reg;
   wire logic rd_low = bus_req.rd && bus_req.addr == ADDR_COUNT_LOW;
   wire logic rd_high = bus_req.rd && bus_req.addr == ADDR_COUNT_HIGH;
   wire logic rd_start = bus_req.rd && bus_req.addr == ADDR_START;
   wire logic rd_en = bus_req.rd && bus_req.addr == ADDR_IRQ_ENABLE;
   wire logic rd_rel = bus_req.rd && bus_req.addr == ADDR_RELOAD;
   wire logic wr_rel = bus_req.wr && bus_req.addr == ADDR_RELOAD;
   wire logic wr_arm = bus_req.wr && bus_req.addr == ADDR_IRQ_ENABLE && bus_req.wdata[ARM_BIT];
   wire logic wr_go = bus_req.wr && bus_req.addr == ADDR_START && bus_req.wdata[START_BIT];
   wire logic mapped = bus_req.addr inside {ADDR_RELOAD, ADDR_IRQ_ENABLE, ADDR_IRQ_PRIORITY,
      ADDR_START, ADDR_COUNT_LOW, ADDR_COUNT_HIGH, ADDR_EVT_STATUS, ADDR_EVT_MASK};

   // Only an external reset stops the counter, so the flag never falls otherwise
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         started_reg <= 1'b0;
      end else if (wr_go) begin
         started_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hi_cnt_reg <= 0;
      end else begin
         hi_cnt_reg <= wd_reset_out ? hi_cnt_reg + 1 : 0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_read_idle_zero: assert property (!bus_req.rd |=> rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_read_zero: assert property (bus_req.rd && !mapped |=> rdata == READ_UNMAPPED)
      else $error("unmapped read not zero");
   a_reload_read_back: assert property (wr_rel ##2 rd_rel
      |=> rdata == $past(bus_req.wdata, 3))
      else $error("reload register lost a write");
   a_stopped_high_load: assert property (wr_rel && !started_reg ##2 rd_high
      |=> rdata == {1'b0, $past(bus_req.wdata[6:0], 3)})
      else $error("high byte not loaded while stopped");
   a_stopped_low_zero: assert property (rd_low && !started_reg |=> rdata == 8'h00)
      else $error("low byte not zero while stopped");
   a_running_no_stop: assert property (rd_start && started_reg && !wd_reset_out
      |=> rdata[START_BIT])
      else $error("started watchdog reads stopped");
   a_arm_bit_set: assert property (wr_arm ##2 rd_en |=> rdata[ARM_BIT])
      else $error("arm bit not held after write");
   a_arm_self_clear: assert property (wr_arm ##37 rd_en |=> !rdata[ARM_BIT])
      else $error("arm bit still set after three machine cycles");
   a_wdreset_clear_en: assert property (wd_reset_out && rd_en |=> rdata == 8'h00)
      else $error("enable register not cleared by watchdog reset");
   a_pulse_length: assert property ($fell(wd_reset_out)
      |-> hi_cnt_reg == PULSE_FAST || hi_cnt_reg == PULSE_SLOW)
      else $error("watchdog reset pulse length wrong");
endmodule

bind wdtr_top wdtr_props u_wdtr_props (.clk(clk), .resetn(resetn), .bus_req(bus_req),
   .rdata(rdata), .wd_reset_out(wd_reset_out), .irq(irq));

// File: testbench/wdtr_cpu.sv
// Core model that reaches the watchdog registers over the plain port.
// Assumes one-cycle strobes and read data in the cycle after the read.
`timescale 1ns/1ps
module wdtr_cpu (
   input wire logic clk,
   output wdtr_pkg::wdtr_bus_req_t bus_req,
   input wire logic [7:0] rdata
);
   import wdtr_pkg::*;
   int seed = 28;

   function automatic logic [7:0] rnd();
      return 8'($random(seed));
   endfunction

   // Idle cycles carry junk so a stale address is never mistaken for a request
   function automatic wdtr_bus_req_t idle();
      return '{rnd(), rnd(), 1'b0, 1'b0};
   endfunction

   initial bus_req = idle();

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      bus_req <= '{a, v, 1'b1, 1'b0};
      @(posedge clk);
      bus_req <= idle();
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      bus_req <= '{a, rnd(), 1'b0, 1'b1};
      @(posedge clk);
      bus_req <= idle();
      @(posedge clk);
      v = rdata;
   endtask

   // A gap over three machine cycles makes the refresh miss on purpose
   task automatic refresh(input int gap);
      wr(ADDR_IRQ_ENABLE, 8'h41);
      repeat (gap) @(posedge clk);
      wr(ADDR_START, 8'h40);
   endtask
endmodule

// File: testbench/wdtr_top_tb.sv
// Self-checking bench of the watchdog block with a core model.
// Assumes wdtr_cpu, the checker and the design are compiled before it.
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
   $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module wdtr_top_tb;
   import wdtr_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   wdtr_bus_req_t bus_req;
   logic [7:0] rdata;
   logic wd_reset_out;
   logic irq;
   int failures = 0;
   int total_checks = 0;
   int n;
   logic [7:0] d;
   logic [7:0] rel_m;

   always #4 clk = ~clk;

   wdtr_top u_wdtr_top (.clk(clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
      .wd_reset_out(wd_reset_out), .irq(irq));
   wdtr_cpu u_wdtr_cpu (.clk(clk), .bus_req(bus_req), .rdata(rdata));

   task automatic final_report();
      if (failures == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      u_wdtr_cpu.rd(a, d);
      `CHK(d & m, e & m)
   endtask

   // Bounded wait; running out counts as a mismatch and ends the run
   task automatic wait_lvl(input logic lvl, input int lim);
      n = 0;
      while (wd_reset_out !== lvl && n < lim) begin
         @(posedge clk);
         n++;
      end
      if (n >= lim) begin
         failures++;
         final_report();
      end
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rchk(ADDR_RELOAD, RELOAD_RESET, 8'hFF);
      rchk(ADDR_IRQ_PRIORITY, IRQ_PRIORITY_RESET, 8'h40);
      rchk(ADDR_IRQ_ENABLE, IRQ_ENABLE_RESET, 8'hFF);
      rchk(ADDR_START, 8'h00, 8'h40);
      rchk(ADDR_COUNT_LOW, 8'h00, 8'hFF);
      rchk(8'h55, READ_UNMAPPED, 8'hFF);
      for (int i = 0; i < 4; i++) begin
         rel_m = u_wdtr_cpu.rnd() & 8'h7F;
         u_wdtr_cpu.wr(ADDR_RELOAD, rel_m);
         rchk(ADDR_COUNT_HIGH, rel_m, 8'hFF);
         rchk(ADDR_RELOAD, rel_m, 8'hFF);
      end
      u_wdtr_cpu.wr(ADDR_EVT_MASK, 8'h01);
      u_wdtr_cpu.wr(ADDR_START, 8'h40);
      rchk(ADDR_COUNT_HIGH, rel_m, 8'hFF);
      rchk(ADDR_EVT_STATUS, 8'h04, 8'h07);
      `CHK(irq, 1'b0)
      u_wdtr_cpu.wr(ADDR_EVT_MASK, 8'h05);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      u_wdtr_cpu.wr(ADDR_EVT_STATUS, 8'h07);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      u_wdtr_cpu.wr(ADDR_START, 8'h00);
      rchk(ADDR_START, 8'h40, 8'h40);
      u_wdtr_cpu.refresh(40);
      rchk(ADDR_EVT_STATUS, 8'h00, 8'h02);
      u_wdtr_cpu.refresh(0);
      rchk(ADDR_EVT_STATUS, 8'h02, 8'h02);
      u_wdtr_cpu.wr(ADDR_IRQ_ENABLE, 8'h41);
      rchk(ADDR_IRQ_ENABLE, 8'h41, 8'hFF);
      u_wdtr_cpu.wr(ADDR_IRQ_ENABLE, 8'h41);
      repeat (35) @(posedge clk);
      rchk(ADDR_IRQ_ENABLE, 8'h01, 8'hFF);
      u_wdtr_cpu.refresh(0);
      repeat (57) @(posedge clk);
      rchk(ADDR_COUNT_LOW, 8'h02, 8'hFF);
      u_wdtr_cpu.wr(ADDR_RELOAD, 8'h90);
      rchk(ADDR_RELOAD, 8'h90, 8'hFF);
      u_wdtr_cpu.refresh(0);
      repeat (2300) @(posedge clk);
      rchk(ADDR_COUNT_LOW, 8'h01, 8'hFF);
      // Pass 0 clears the source flag by software, pass 1 by external reset
      for (int p = 0; p < 2; p++) begin
         rel_m = 8'h7F;
         u_wdtr_cpu.wr(ADDR_RELOAD, rel_m);
         u_wdtr_cpu.refresh(0);
         wait_lvl(1'b1, 7000);
         rchk(ADDR_COUNT_LOW, 8'hFC, 8'hFF);
         rchk(ADDR_IRQ_ENABLE, 8'h00, 8'hFF);
         `CHK(irq, 1'b1)
         wait_lvl(1'b0, 200);
         `CHK(n + 6, 4 * PRESCALE_FAST * CLK_PER_CYCLE)
         rchk(ADDR_IRQ_PRIORITY, 8'h40, 8'h40);
         rchk(ADDR_START, 8'h40, 8'h40);
         rchk(ADDR_COUNT_HIGH, rel_m, 8'hFF);
         if (p == 0) begin
            u_wdtr_cpu.wr(ADDR_IRQ_PRIORITY, 8'h00);
            rchk(ADDR_IRQ_PRIORITY, 8'h00, 8'h40);
         end else begin
            resetn <= 1'b0;
            @(posedge clk);
            resetn <= 1'b1;
            rchk(ADDR_IRQ_PRIORITY, 8'h00, 8'h40);
            rchk(ADDR_RELOAD, 8'h00, 8'hFF);
            rchk(ADDR_START, 8'h00, 8'h40);
         end
      end
      final_report();
   end
endmodule
